// ---- design/snsb_defs.svh ----
// Constants for the serial NAND status and bad-block command decoder
`ifndef SNSB_DEFS_SVH
`define SNSB_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SNSB_REF_PERIOD_NS 10
`define SNSB_T_RST_NS 5000
`define SNSB_RST_CYCLES \
  ((`SNSB_T_RST_NS + `SNSB_REF_PERIOD_NS - 1) / `SNSB_REF_PERIOD_NS)

// ----------------------------------------------------------------------
// Frame layout in link clocks
// ----------------------------------------------------------------------
`define SNSB_OP_BITS 8
`define SNSB_WSR_BITS 24
`define SNSB_LINK_BITS 40
`define SNSB_ADDR_END 15
`define SNSB_OUT_START 16
`define SNSB_CNT_W 11
`define SNSB_CNT_MAX 11'h7ff
`define SNSB_CNT_WRAP 11'h400
`define SNSB_ID_BITS 24
`define SNSB_FAIL_BITS 16
`define SNSB_LINK_WORD 32

// ----------------------------------------------------------------------
// Register addresses (upper nibble) and fields
// ----------------------------------------------------------------------
`define SNSB_ADDR_PROT 4'ha
`define SNSB_ADDR_CONF 4'hb
`define SNSB_ADDR_STAT 4'hc
`define SNSB_PROT_RESET 8'h7c
`define SNSB_CONF_RESET 8'h10
`define SNSB_CONF_WMASK 8'hf8
`define SNSB_CONF_ECC_EN 4
`define SNSB_CONF_BUF 3
`define SNSB_ECC_UNCORR 1
`define SNSB_LUT_DEPTH 20
`define SNSB_LINK_ENABLED 2'h2
`define SNSB_BLANK_BYTE 8'hff

`endif

// ---- design/snsb_pkg.sv ----
// Types shared by the status and bad-block command decoder
package snsb_pkg;

  // --------------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------------
  typedef enum logic [7:0] {
    SNSB_OP_ID = 8'h9f,
    SNSB_OP_STAT_RD_A = 8'h0f,
    SNSB_OP_STAT_RD_B = 8'h05,
    SNSB_OP_STAT_WR_A = 8'h1f,
    SNSB_OP_STAT_WR_B = 8'h01,
    SNSB_OP_WR_EN = 8'h06,
    SNSB_OP_WR_DIS = 8'h04,
    SNSB_OP_LINK = 8'ha1,
    SNSB_OP_LUT_RD = 8'ha5,
    SNSB_OP_FAIL_RD = 8'ha9,
    SNSB_OP_RESET = 8'hff
  } snsb_op_e;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] arg;
  } snsb_cmd_s;

  typedef struct packed {
    logic [7:0] prot;
    logic [7:0] conf;
    logic [7:0] stat;
  } snsb_stat_s;

endpackage : snsb_pkg

// ---- design/snsb_sync.sv ----
// Two-stage synchroniser for levels and quasi-static words
`timescale 1ns/10ps

module snsb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : snsb_sync

// ---- design/snsb_spi_cmd.sv ----
// Serial NAND status, identification and bad-block command decoder
`timescale 1ns/10ps
`include "snsb_defs.svh"

module snsb_spi_cmd
  import snsb_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,    // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h3c21, // Arbitrary value
  parameter int LUT_DEPTH = `SNSB_LUT_DEPTH,
  parameter int RST_CYCLES = `SNSB_RST_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SPI_CLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_DI,
  input wire logic ARRAY_BUSY,
  input wire logic OP_DONE,
  input wire logic PROG_FAIL,
  input wire logic ERASE_FAIL,
  input wire logic ECC_VALID,
  input wire logic [1:0] ECC_CODE,
  input wire logic [15:0] ECC_PAGE,
  input wire logic MARK_VALID,
  input wire logic [7:0] MARK_BYTE,
  output logic SPI_DO,
  output logic SPI_DO_OE,
  output logic WRITE_ENABLE_LATCH,
  output logic BUSY,
  output logic ECC_ENABLE,
  output logic BUF_MODE,
  output logic LINK_TABLE_FULL,
  output logic BAD_BLOCK_FOUND,
  output logic [7:0] PROTECT_REG
);

  localparam int CW = $clog2(LUT_DEPTH + 1);
  localparam int RW = $clog2(RST_CYCLES + 1);
  localparam int TW = `SNSB_CNT_W;

  // ----------------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------------
  function automatic logic [5:0] exec_len(input logic [7:0] op);
    case (op)
      SNSB_OP_WR_EN, SNSB_OP_WR_DIS, SNSB_OP_RESET: exec_len = 6'd8;
      SNSB_OP_STAT_WR_A, SNSB_OP_STAT_WR_B: exec_len = 6'd24;
      SNSB_OP_LINK: exec_len = 6'd40;
      default: exec_len = 6'd0;
    endcase
  endfunction : exec_len

  function automatic logic is_read(input logic [7:0] op);
    case (op)
      SNSB_OP_ID, SNSB_OP_STAT_RD_A, SNSB_OP_STAT_RD_B,
      SNSB_OP_LUT_RD, SNSB_OP_FAIL_RD: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
  endfunction : is_read

  // ----------------------------------------------------------------------
  // State held on the reference clock
  // ----------------------------------------------------------------------
  logic [7:0] prot;
  logic [7:0] conf;
  logic write_enable_latch;
  logic [1:0] ecc_st;
  logic pfail;
  logic efail;
  logic busy;
  logic [RW-1:0] rst_cnt;
  logic [CW-1:0] lut_count;
  logic lut_full;
  logic [15:0] fail_addr;
  logic bad_found;
  logic tog_seen;
  logic [15:0] lut_lba [LUT_DEPTH];
  logic [15:0] lut_pba [LUT_DEPTH];

  // ----------------------------------------------------------------------
  // Link side: shifting in
  // ----------------------------------------------------------------------
  logic [TW-1:0] bit_cnt;
  logic [7:0] op_sh;
  logic [31:0] arg_sh;
  logic [7:0] rd_addr;
  snsb_cmd_s hold_cmd;
  logic cmd_tog;

  wire [7:0] full_op = {op_sh[6:0], SPI_DI};
  wire [7:0] cur_op = (bit_cnt == TW'(7)) ? full_op : op_sh;
  wire [5:0] need = exec_len(cur_op);
  wire cmd_done = (need != 6'd0) && (bit_cnt == TW'(need - 6'd1));
  // Wrap keeps the low three bits running, so a status byte repeats
  wire [TW-1:0] next_cnt = (bit_cnt == `SNSB_CNT_MAX) ? `SNSB_CNT_WRAP
                                                      : bit_cnt + TW'(1);
  wire in_op = bit_cnt < TW'(`SNSB_OP_BITS);

  // Frame state dies with deselect; the link clock stops between frames
  always_ff @(posedge SPI_CLK or posedge SPI_CS_N) begin
    if (SPI_CS_N) begin
      bit_cnt <= '0;
      op_sh <= 8'h00;
      arg_sh <= 32'h0000_0000;
    end else begin
      bit_cnt <= next_cnt;
      op_sh <= in_op ? full_op : op_sh;
      arg_sh <= in_op ? arg_sh : {arg_sh[30:0], SPI_DI};
    end
  end

  always_ff @(posedge SPI_CLK or posedge SPI_CS_N) begin
    if (SPI_CS_N) begin
      rd_addr <= 8'h00;
    end else if (bit_cnt == TW'(`SNSB_ADDR_END)) begin
      rd_addr <= {arg_sh[6:0], SPI_DI};
    end
  end

  // Held command stays stable until the next complete one
  always_ff @(posedge SPI_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_cmd <= '0;
      cmd_tog <= 1'b0;
    end else if (cmd_done) begin
      hold_cmd.op <= cur_op;
      hold_cmd.arg <= {arg_sh[30:0], SPI_DI};
      cmd_tog <= ~cmd_tog;
    end
  end

  // ----------------------------------------------------------------------
  // Link side: shifting out
  // ----------------------------------------------------------------------
  snsb_stat_s stat_ref;
  logic [23:0] stat_spi;
  logic [15:0] fail_spi;

  // Bits may tear by one read when two flags change at once; harmless here
  snsb_sync #(.WIDTH(24), .INIT(24'h000000)) u_stat_sync (
    .clk(SPI_CLK),
    .rst_n(1'b1),
    .d(stat_ref),
    .q(stat_spi)
  );

  snsb_sync #(.WIDTH(16), .INIT(16'h0000)) u_fail_sync (
    .clk(SPI_CLK),
    .rst_n(1'b1),
    .d(fail_addr),
    .q(fail_spi)
  );

  wire [TW-1:0] out_idx = bit_cnt - TW'(`SNSB_OUT_START);
  wire rd_active = is_read(op_sh) && !in_op &&
                   (bit_cnt >= TW'(`SNSB_OUT_START));
  wire [4:0] lut_idx = out_idx[9:5];
  wire lut_hit = out_idx < TW'(LUT_DEPTH * `SNSB_LINK_WORD);
  // Table only changes after deselect, so it is static while read here
  wire [31:0] lut_word = lut_hit ? {lut_lba[lut_idx], lut_pba[lut_idx]}
                                 : 32'h0000_0000;
  wire [23:0] id_word = {MFR_ID, DEV_ID};
  wire [7:0] stat_byte =
    (rd_addr[7:4] == `SNSB_ADDR_PROT) ? stat_spi[23:16] :
    (rd_addr[7:4] == `SNSB_ADDR_CONF) ? stat_spi[15:8] :
    (rd_addr[7:4] == `SNSB_ADDR_STAT) ? stat_spi[7:0] : 8'h00;
  logic next_bit;

  always_comb begin
    next_bit = 1'b0;
    case (op_sh)
      SNSB_OP_ID: begin
        if (out_idx < TW'(`SNSB_ID_BITS)) begin
          next_bit = id_word[5'd23 - out_idx[4:0]];
        end
      end
      SNSB_OP_STAT_RD_A, SNSB_OP_STAT_RD_B: begin
        next_bit = stat_byte[3'd7 - out_idx[2:0]];
      end
      SNSB_OP_LUT_RD: begin
        next_bit = lut_word[5'd31 - out_idx[4:0]];
      end
      SNSB_OP_FAIL_RD: begin
        if (out_idx < TW'(`SNSB_FAIL_BITS)) begin
          next_bit = fail_spi[4'd15 - out_idx[3:0]];
        end
      end
      default: next_bit = 1'b0;
    endcase
  end

  always_ff @(negedge SPI_CLK or posedge SPI_CS_N) begin
    if (SPI_CS_N) begin
      SPI_DO <= 1'b0;
      SPI_DO_OE <= 1'b0;
    end else begin
      SPI_DO <= rd_active & next_bit;
      SPI_DO_OE <= rd_active;
    end
  end

  // ----------------------------------------------------------------------
  // Crossing into the reference clock
  // ----------------------------------------------------------------------
  logic cs_ref;
  logic tog_ref;

  snsb_sync #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(SPI_CS_N),
    .q(cs_ref)
  );

  snsb_sync #(.WIDTH(1), .INIT(1'b0)) u_tog_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(cmd_tog),
    .q(tog_ref)
  );

  // Commands run only once deselected; none are taken while resetting
  wire exec = cs_ref && (tog_ref != tog_seen) && (rst_cnt == '0);
  wire do_wren = exec && (hold_cmd.op == SNSB_OP_WR_EN);
  wire do_wrdi = exec && (hold_cmd.op == SNSB_OP_WR_DIS);
  wire do_reset = exec && (hold_cmd.op == SNSB_OP_RESET);
  wire do_link = exec && (hold_cmd.op == SNSB_OP_LINK);
  wire do_wsr = exec && ((hold_cmd.op == SNSB_OP_STAT_WR_A) ||
                         (hold_cmd.op == SNSB_OP_STAT_WR_B));
  wire [7:0] wsr_addr = hold_cmd.arg[15:8];
  wire [7:0] wsr_data = hold_cmd.arg[7:0];
  wire [15:0] link_lba = hold_cmd.arg[31:16];
  wire [15:0] link_pba = hold_cmd.arg[15:0];
  wire ecc_en = conf[`SNSB_CONF_ECC_EN];
  wire buf_mode = conf[`SNSB_CONF_BUF];
  wire ecc_take = ECC_VALID && ecc_en;
  wire keep_uncorr = !buf_mode && ecc_st[`SNSB_ECC_UNCORR] &&
                     !ECC_CODE[`SNSB_ECC_UNCORR];
  wire [1:0] next_ecc = keep_uncorr ? ecc_st : ECC_CODE;
  wire link_ok = do_link && (lut_count < CW'(LUT_DEPTH));
  wire [CW-1:0] next_count = link_ok ? lut_count + CW'(1) : lut_count;

  always_comb begin
    stat_ref.prot = prot;
    stat_ref.conf = conf;
    stat_ref.stat = {1'b0, lut_full, ecc_st, pfail, efail, write_enable_latch, busy};
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tog_seen <= tog_ref;
    end else if (cs_ref) begin
      tog_seen <= tog_ref;
    end
  end

  // ----------------------------------------------------------------------
  // Status and configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      prot <= `SNSB_PROT_RESET;
      conf <= `SNSB_CONF_RESET;
    end else if (do_wsr && wsr_addr[7:4] == `SNSB_ADDR_PROT) begin
      prot <= wsr_data;
    end else if (do_wsr && wsr_addr[7:4] == `SNSB_ADDR_CONF) begin
      conf <= (conf & ~`SNSB_CONF_WMASK) |
              (wsr_data & `SNSB_CONF_WMASK);
    end
  end

  // The host's set wins over a completion clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      write_enable_latch <= 1'b0;
    end else if (do_wren) begin
      write_enable_latch <= 1'b1;
    end else if (do_wrdi) begin
      write_enable_latch <= 1'b0;
    end else if (OP_DONE || do_reset) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ecc_st <= 2'h0;
    end else if (ecc_take) begin
      ecc_st <= next_ecc;
    end else if (do_reset) begin
      ecc_st <= 2'h0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      fail_addr <= 16'h0000;
    end else if (ecc_take && ECC_CODE[`SNSB_ECC_UNCORR]) begin
      fail_addr <= ECC_PAGE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pfail <= 1'b0;
      efail <= 1'b0;
    end else begin
      pfail <= (OP_DONE && PROG_FAIL) || (pfail && !do_reset);
      efail <= (OP_DONE && ERASE_FAIL) || (efail && !do_reset);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rst_cnt <= '0;
      busy <= 1'b0;
    end else begin
      rst_cnt <= do_reset ? RW'(RST_CYCLES)
                          : rst_cnt - RW'(rst_cnt != '0);
      busy <= ARRAY_BUSY || do_reset || (rst_cnt > RW'(1));
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bad_found <= 1'b0;
    end else if (MARK_VALID) begin
      bad_found <= MARK_BYTE != `SNSB_BLANK_BYTE;
    end
  end

  // ----------------------------------------------------------------------
  // Link table
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      lut_count <= '0;
      lut_full <= 1'b0;
    end else begin
      lut_count <= next_count;
      lut_full <= next_count == CW'(LUT_DEPTH);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < LUT_DEPTH; i++) begin
        lut_lba[i] <= 16'h0000;
        lut_pba[i] <= 16'h0000;
      end
    end else if (link_ok) begin
      lut_lba[lut_count] <= {`SNSB_LINK_ENABLED, link_lba[13:0]};
      lut_pba[lut_count] <= link_pba;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to the array engine
  // ----------------------------------------------------------------------
  always_comb begin
    WRITE_ENABLE_LATCH = write_enable_latch;
    BUSY = busy;
    ECC_ENABLE = ecc_en;
    BUF_MODE = buf_mode;
    LINK_TABLE_FULL = lut_full;
    BAD_BLOCK_FOUND = bad_found;
    PROTECT_REG = prot;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_exec_op(logic [7:0] o);
    exec && (hold_cmd.op == o);
  endsequence

  chk_wel_set: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    s_exec_op(SNSB_OP_WR_EN) |=> write_enable_latch)
    else $error("write enable did not set the latch");

  chk_wel_clear: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    s_exec_op(SNSB_OP_WR_DIS) |=> !write_enable_latch)
    else $error("write disable did not clear the latch");

  chk_wel_auto: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (OP_DONE && !do_wren) |=> !write_enable_latch)
    else $error("latch survived operation completion");

  chk_conf_ro: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (do_wsr && wsr_addr[7:4] == `SNSB_ADDR_CONF) |=>
      (conf[2:0] == $past(conf[2:0])) && (conf[7:3] == $past(wsr_data[7:3])))
    else $error("configuration write touched read-only bits");

  chk_reset_vals: assert property (@(posedge REF_CLK)
    !RST_N |=> (prot == `SNSB_PROT_RESET) && (conf == `SNSB_CONF_RESET))
    else $error("register reset values wrong");

  chk_table_full: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (lut_full == (lut_count == CW'(LUT_DEPTH))) and
    ((do_link && lut_full) |=> $stable(lut_count)))
    else $error("link table full handling wrong");

  chk_reset_busy: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    s_exec_op(SNSB_OP_RESET) |=> (busy && !write_enable_latch && ecc_st == 2'h0)[*8])
    else $error("reset command did not hold busy and clear flags");

  chk_fail_last: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (ecc_take && ECC_CODE[1]) |=> fail_addr == $past(ECC_PAGE))
    else $error("failure page address not captured");

  chk_ecc_keep: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (ecc_take && keep_uncorr) |=> ecc_st[1])
    else $error("uncorrectable status lost in continuous mode");

  chk_quiet_bad: assert property (
    @(negedge SPI_CLK) disable iff (SPI_CS_N)
    (!in_op && !is_read(op_sh)) |=> !SPI_DO_OE)
    else $error("output driven for a command without data out");

  chk_id_first: assert property (
    @(negedge SPI_CLK) disable iff (SPI_CS_N)
    (bit_cnt == TW'(`SNSB_OUT_START) && op_sh == SNSB_OP_ID) |=>
      SPI_DO_OE && (SPI_DO == MFR_ID[7]))
    else $error("identification did not start with maker MSB");

endmodule : snsb_spi_cmd

// ---- verification/snsb_host_model.sv ----
// SPI host model that frames commands and collects the serial reply
`timescale 1ns/10ps

module snsb_host_model
  import snsb_pkg::*;
#(
  parameter realtime HALF = 62.5
) (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_di,
  input wire logic spi_do,
  input wire logic spi_do_oe,
  output logic drive_seen
);
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b0;
    spi_di = 1'b0;
    drive_seen = 1'b0;
    // A real rising select clears the frame logic, which has no other reset
    #1 spi_cs_n = 1'b1;
  end

  // ----
  // Frame
  // ----
  // Clock idles low between frames; the offset keeps it off the REF grid
  task automatic xfer(input logic [63:0] tx, input int n,
                      output logic [63:0] rx);
    int i;
    rx = '0;
    drive_seen = 1'b0;
    #3.3;
    spi_cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      spi_di = (i < 64) ? tx[63 - i] : 1'b0;
      #(HALF);
      spi_clk = 1'b1;
      rx = {rx[62:0], spi_do};
      drive_seen = drive_seen | spi_do_oe;
      #(HALF);
      spi_clk = 1'b0;
    end
    #(HALF);
    spi_cs_n = 1'b1;
    // Released line must not keep its last value
    spi_di = ~spi_di;
    #(2 * HALF);
  endtask : xfer
endmodule : snsb_host_model

// ---- verification/spi_nand_status_bbm_cmds_bench.sv ----
// Self-checking bench for the status and bad-block command decoder
`timescale 1ns/10ps

module spi_nand_status_bbm_cmds_bench;
  import snsb_pkg::*;
  localparam logic [7:0] MFR = 8'h5a;    // Arbitrary value
  localparam logic [15:0] DEV = 16'h3c21; // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  logic array_busy = 1'b0;
  logic op_done = 1'b0;
  logic prog_fail = 1'b0;
  logic erase_fail = 1'b0;
  logic ecc_valid = 1'b0;
  logic [1:0] ecc_code = 2'h0;
  logic [15:0] ecc_page = 16'h0;
  logic mark_valid = 1'b0;
  logic [7:0] mark_byte = 8'hff;
  logic spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe, seen;
  logic write_enable_latch, busy, ecc_en, buf_mode, full, bad;
  logic [7:0] prot;
  logic [63:0] rx;
  int num_errors = 0;
  int checks_done = 0;
  int i;

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  snsb_host_model snsb_host_model_i (.spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_di(spi_di), .spi_do(spi_do),
    .spi_do_oe(spi_do_oe), .drive_seen(seen));

  snsb_spi_cmd #(.MFR_ID(MFR), .DEV_ID(DEV), .RST_CYCLES(20))
  snsb_spi_cmd_i (.REF_CLK(ref_clk), .RST_N(rst_n), .SPI_CLK(spi_clk),
    .SPI_CS_N(spi_cs_n), .SPI_DI(spi_di), .ARRAY_BUSY(array_busy),
    .OP_DONE(op_done), .PROG_FAIL(prog_fail), .ERASE_FAIL(erase_fail),
    .ECC_VALID(ecc_valid), .ECC_CODE(ecc_code), .ECC_PAGE(ecc_page),
    .MARK_VALID(mark_valid), .MARK_BYTE(mark_byte), .SPI_DO(spi_do),
    .SPI_DO_OE(spi_do_oe), .WRITE_ENABLE_LATCH(write_enable_latch), .BUSY(busy),
    .ECC_ENABLE(ecc_en), .BUF_MODE(buf_mode), .LINK_TABLE_FULL(full),
    .BAD_BLOCK_FOUND(bad), .PROTECT_REG(prot));

  // ----
  // Tasks
  // ----
  task automatic final_report();
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Gap after each frame lets the REF side carry the command out
  task automatic cmd(input logic [63:0] tx, input int n);
    snsb_host_model_i.xfer(tx, n, rx);
    repeat (6) @(negedge ref_clk);
  endtask : cmd

  // Two copies of the byte show that it repeats while selected
  task automatic rd_reg(input logic [7:0] op, input logic [7:0] a,
                        input logic [7:0] exp);
    cmd({op, a, 48'h0}, 32);
    check(rx[15:0], {exp, exp});
    check(seen, 1'b1);
  endtask : rd_reg

  task automatic ecc_ev(input logic [1:0] code, input logic [15:0] page);
    ecc_code = code;
    ecc_page = page;
    ecc_valid = 1'b1;
    @(negedge ref_clk);
    ecc_valid = 1'b0;
    @(negedge ref_clk);
  endtask : ecc_ev

  task automatic mark(input logic [7:0] b, input logic exp);
    mark_byte = b;
    mark_valid = 1'b1;
    @(negedge ref_clk);
    mark_valid = 1'b0;
    @(negedge ref_clk);
    check(bad, exp);
  endtask : mark

  // ----
  // Sequence
  // ----
  initial begin
    // Reset falls after time zero so the link side sees a real edge
    #1 rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(write_enable_latch, 1'b0);
    check({ecc_en, buf_mode, full, prot}, {3'b100, 8'h7c});
    rd_reg(8'h0f, 8'hb0, 8'h10);
    cmd({8'h9f, 56'h0}, 40);
    check(rx[23:0], {MFR, DEV});
    cmd({8'h5e, 56'h0}, 32);
    check(seen, 1'b0);
    cmd({8'h06, 56'h0}, 7);
    check(write_enable_latch, 1'b0);
    cmd({8'h06, 56'h0}, 8);
    check(write_enable_latch, 1'b1);
    rd_reg(8'h05, 8'hc0, 8'h02);
    cmd({8'h04, 56'h0}, 8);
    check(write_enable_latch, 1'b0);
    cmd({8'h06, 56'h0}, 8);
    prog_fail = 1'b1;
    erase_fail = 1'b1;
    op_done = 1'b1;
    @(negedge ref_clk);
    op_done = 1'b0;
    prog_fail = 1'b0;
    erase_fail = 1'b0;
    @(negedge ref_clk);
    check(write_enable_latch, 1'b0);
    cmd({8'h1f, 8'ha0, 8'hff, 40'h0}, 24);
    check(prot, 8'hff);
    rd_reg(8'h0f, 8'ha0, 8'hff);
    cmd({8'h01, 8'hb0, 8'h1f, 40'h0}, 24);
    rd_reg(8'h0f, 8'hb0, 8'h18);
    check(buf_mode, 1'b1);
    cmd({8'h01, 8'hc0, 8'hff, 40'h0}, 24);
    rd_reg(8'h05, 8'hc0, 8'h0c);
    cmd({8'h01, 8'hb0, 8'h10, 40'h0}, 24);
    check(buf_mode, 1'b0);
    ecc_ev(2'b10, 16'h1234);
    ecc_ev(2'b10, 16'h0abc);
    ecc_ev(2'b00, 16'h0001);
    rd_reg(8'h05, 8'hc0, 8'h2c);
    cmd({8'ha9, 56'h0}, 32);
    check(rx[15:0], 16'h0abc);
    array_busy = 1'b1;
    rd_reg(8'h05, 8'hc0, 8'h2d);
    array_busy = 1'b0;
    // Buffer mode: a later result overwrites an uncorrectable one
    cmd({8'h1f, 8'hb0, 8'h18, 40'h0}, 24);
    ecc_ev(2'b10, 16'h0555);
    ecc_ev(2'b01, 16'h0002);
    rd_reg(8'h05, 8'hc0, 8'h1c);
    cmd({8'h01, 8'hb0, 8'h10, 40'h0}, 24);
    check(buf_mode, 1'b0);
    mark(8'hfe, 1'b1);
    mark(8'hff, 1'b0);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'hff, 56'h0}, 8);
    check({busy, write_enable_latch}, 2'b10);
    for (i = 0; i < 100 && busy !== 1'b0; i++) begin
      @(negedge ref_clk);
    end
    check(busy, 1'b0);
    if (busy !== 1'b0) begin
      final_report();
    end
    rd_reg(8'h05, 8'hc0, 8'h00);
    cmd({8'ha5, 56'h0}, 80);
    check(rx, 64'h0);
    for (i = 0; i < 20; i++) begin
      check(full, 1'b0);
      cmd({8'ha1, 16'h4000 + i[15:0], 16'h0100 + i[15:0], 24'h0}, 40);
    end
    check(full, 1'b1);
    rd_reg(8'h05, 8'hc0, 8'h40);
    cmd({8'ha1, 16'h0077, 16'h0377, 24'h0}, 40);
    cmd({8'ha5, 56'h0}, 80);
    check(rx, {16'h8000, 16'h0100, 16'h8001, 16'h0101});
    cmd({8'ha5, 56'h0}, 688);
    check(rx, {16'h8013, 16'h0113, 32'h0});
    final_report();
  end
endmodule : spi_nand_status_bbm_cmds_bench
